// file: design/comp_regs_pkg.sv
// Constants shared by the compensation and threshold register bank
// ---------------------------------------------------------------
// ---------------------------------------------------------------
package comp_regs_pkg;
  localparam int unsigned INDEX_W = 8;
  localparam int unsigned ADDR_LSB = 2;
  localparam logic [7:0] IDX_ALARM_CFG = 8'h08;
  localparam logic [7:0] IDX_THRESH_HIGH = 8'h09;
  localparam logic [7:0] IDX_THRESH_LOW = 8'h0a;
  localparam logic [7:0] IDX_PRES_HIGH = 8'h0b;
  localparam logic [7:0] IDX_PRES_LOW = 8'h0c;
  localparam logic [7:0] IDX_REF_HIGH = 8'h0d;
  localparam logic [7:0] IDX_REF_LOW = 8'h0e;
  localparam logic [7:0] IDX_STATUS = 8'h20;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h21;
  localparam logic [7:0] IDX_SHADOW_HIGH = 8'h22;
  localparam logic [7:0] IDX_SHADOW_LOW = 8'h23;
  localparam logic [7:0] RST_THRESH_HIGH = 8'h00;
  localparam logic [7:0] RST_THRESH_LOW = 8'h00;
  localparam logic [7:0] RST_PRES_HIGH = 8'h03;
  localparam logic [7:0] RST_PRES_LOW = 8'hf7;
  localparam logic [7:0] RST_REF_HIGH = 8'h01;
  localparam logic [7:0] RST_REF_LOW = 8'h90;
  localparam logic RST_ALARM_DIR = 1'b1;
  localparam logic RST_MASK = 1'b0;
  localparam logic [15:0] PRES_DEFAULT = {RST_PRES_HIGH, RST_PRES_LOW};
  localparam logic [15:0] PRES_MIN = 16'h02ee;
  localparam logic [15:0] PRES_MAX = 16'h047e;
  localparam logic [15:0] REF_MIN = 16'h015e;
  localparam logic [15:0] REF_MAX = 16'h05dc;
  localparam int unsigned BIT_COMM_ERR = 0;
  localparam int unsigned BIT_ALARM_DIR = 0;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  // Bus front phases, one-hot
  typedef enum logic [1:0] {
    PH_IDLE = 2'b01,
    PH_DATA = 2'b10
  } bus_phase_e;
endpackage

// file: design/reg_access_if.sv
// Register access strobes between the bus front and the register bank
`timescale 1ns/1ps
`default_nettype none
interface reg_access_if;
  logic wrEn;
  logic [7:0] index;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport front (output wrEn, output index, output wdata, input rdata);
  modport regs (input wrEn, input index, input wdata, output rdata);
endinterface
`default_nettype wire

// file: design/range_clamp.sv
// Saturates a 16-bit value into a closed range and flags the excursion
`timescale 1ns/1ps
`default_nettype none
module range_clamp #(
  parameter logic [15:0] LO = 16'h0000,
  parameter logic [15:0] HI = 16'hffff,
  parameter bit IS_SIGNED = 1'b0
) (
  input wire logic [15:0] value,
  output logic [15:0] clamped,
  output logic outOfRange
);
  logic below;
  logic above;

  // Compare in the number format of the field
  always_comb begin
    if (IS_SIGNED) begin
      below = $signed(value) < $signed(LO);
      above = $signed(value) > $signed(HI);
    end else begin
      below = value < LO;
      above = value > HI;
    end
    outOfRange = below || above;
    clamped = below ? LO : (above ? HI : value);
  end
endmodule // range_clamp
`default_nettype wire

// file: design/ahb_reg_front.sv
// AHB-Lite slave front end that turns word transfers into byte register strobes
`timescale 1ns/1ps
`default_nettype none
module ahb_reg_front (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  reg_access_if.front acc
);
  import comp_regs_pkg::*;

  bus_phase_e phase;
  logic [INDEX_W-1:0] pendIndex;
  logic pendWrite;
  logic pendValid;
  logic take;

  // NONSEQ or SEQ with the bus ready starts an address phase
  assign take = hsel && htrans[1] && hready;

  // One wait state per transfer so read data leaves a flop
  always_ff @(posedge core_clk) begin
    if (rst) begin
      phase <= PH_IDLE;
    end else begin
      case (phase)
        PH_IDLE: phase <= take ? PH_DATA : PH_IDLE;
        PH_DATA: phase <= PH_IDLE;
        default: phase <= PH_IDLE;
      endcase
    end
  end

  // Address phase capture; non-word or out-of-window access is unmapped
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pendIndex <= '0;
      pendWrite <= 1'b0;
      pendValid <= 1'b0;
    end else if (phase == PH_IDLE && take) begin
      pendIndex <= haddr[ADDR_LSB +: INDEX_W];
      pendWrite <= hwrite;
      pendValid <= (hsize == HSIZE_WORD) && (haddr[1:0] == 2'h0) && (haddr[31:10] == 22'h0);
    end
  end

  // Ready low through the data phase, read data registered at its end
  always_ff @(posedge core_clk) begin
    if (rst) begin
      hreadyout <= 1'b1;
      hrdata <= 32'h0;
    end else if (phase == PH_DATA) begin
      hreadyout <= 1'b1;
      hrdata <= (pendValid && !pendWrite) ? {24'h0, acc.rdata} : 32'h0;
    end else begin
      hreadyout <= !take;
    end
  end

  // Strobes to the bank live only in the data phase, when hwdata stands
  assign acc.wrEn = (phase == PH_DATA) && pendWrite && pendValid;
  assign acc.index = pendIndex;
  assign acc.wdata = hwdata[7:0];

  // Every taken transfer stalls the bus for exactly one cycle
  property p_wait_state;
    @(posedge core_clk) disable iff (rst)
    (phase == PH_IDLE && take) |=> !hreadyout ##1 hreadyout;
  endproperty
  a_wait_state: assert property (p_wait_state)
    else $error("transfer did not take exactly one wait state");
endmodule // ahb_reg_front
`default_nettype wire

// file: design/compensation_threshold_regs.sv
// Alarm threshold, pressure compensation and calibration reference registers
//
// The AHB-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module compensation_threshold_regs (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  output logic signed [15:0] alarmThreshold,
  output logic alarmUpward,
  output logic [15:0] pressureComp,
  output logic compEnable,
  output logic signed [15:0] calibReference,
  output logic commError,
  output logic irq
);
  import comp_regs_pkg::*;

  // ---------------------------------------------------------------
  // Bus front end
  // ---------------------------------------------------------------

  reg_access_if acc ();

  ahb_reg_front u_front (
    .core_clk (core_clk),
    .rst (rst),
    .hsel (hsel),
    .haddr (haddr),
    .htrans (htrans),
    .hwrite (hwrite),
    .hsize (hsize),
    .hwdata (hwdata),
    .hready (hready),
    .hreadyout (hreadyout),
    .hrdata (hrdata),
    .acc (acc)
  );

  // Every transfer completes OKAY; kept in a flop like every other output
  always_ff @(posedge core_clk) hresp <= 1'b0;

  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------

  logic [7:0] threshHigh;
  logic [7:0] threshLow;
  logic [7:0] presHigh;
  logic [7:0] presLow;
  logic [15:0] presShadow;
  logic [7:0] refHigh;
  logic [7:0] refLow;
  logic irqMask;
  logic next_commErr;
  logic next_irqMask;

  // ---------------------------------------------------------------
  // Write decode
  // ---------------------------------------------------------------

  logic wrCfg;
  logic wrThreshHigh;
  logic wrThreshLow;
  logic wrPresHigh;
  logic wrPresLow;
  logic wrRefHigh;
  logic wrRefLow;
  logic wrStatus;
  logic wrMask;

  // One strobe per writable register; the shadow bytes have none
  assign wrCfg = acc.wrEn && (acc.index == IDX_ALARM_CFG);
  assign wrThreshHigh = acc.wrEn && (acc.index == IDX_THRESH_HIGH);
  assign wrThreshLow = acc.wrEn && (acc.index == IDX_THRESH_LOW);
  assign wrPresHigh = acc.wrEn && (acc.index == IDX_PRES_HIGH);
  assign wrPresLow = acc.wrEn && (acc.index == IDX_PRES_LOW);
  assign wrRefHigh = acc.wrEn && (acc.index == IDX_REF_HIGH);
  assign wrRefLow = acc.wrEn && (acc.index == IDX_REF_LOW);
  assign wrStatus = acc.wrEn && (acc.index == IDX_STATUS);
  assign wrMask = acc.wrEn && (acc.index == IDX_IRQ_MASK);

  // ---------------------------------------------------------------
  // Range checks
  // ---------------------------------------------------------------

  logic [15:0] presCand;
  logic [15:0] presClamped;
  logic presOut;
  logic [15:0] refCand;
  logic [15:0] refClamped;
  logic refOut;

  // The candidate pairs the held high byte with the incoming low byte
  assign presCand = {presHigh, acc.wdata};

  range_clamp #(
    .LO (PRES_MIN),
    .HI (PRES_MAX),
    .IS_SIGNED (1'b0)
  ) u_pres_clamp (
    .value (presCand),
    .clamped (presClamped),
    .outOfRange (presOut)
  );

  // Either byte of the reference is checked together with the other held byte
  assign refCand = wrRefHigh ? {acc.wdata, refLow} : {refHigh, acc.wdata};

  range_clamp #(
    .LO (REF_MIN),
    .HI (REF_MAX),
    .IS_SIGNED (1'b1)
  ) u_ref_clamp (
    .value (refCand),
    .clamped (refClamped),
    .outOfRange (refOut)
  );

  // ---------------------------------------------------------------
  // Alarm configuration and threshold
  // ---------------------------------------------------------------

  // Direction bit picks lower or upper limit for the comparator
  always_ff @(posedge core_clk) begin
    if (rst) begin
      alarmUpward <= RST_ALARM_DIR;
    end else if (wrCfg) begin
      alarmUpward <= acc.wdata[BIT_ALARM_DIR];
    end
  end

  // Threshold bytes are plain storage
  always_ff @(posedge core_clk) begin
    if (rst) begin
      threshHigh <= RST_THRESH_HIGH;
      threshLow <= RST_THRESH_LOW;
    end else begin
      if (wrThreshHigh) begin
        threshHigh <= acc.wdata;
      end
      if (wrThreshLow) begin
        threshLow <= acc.wdata;
      end
    end
  end

  // Signed threshold, high byte on top
  assign alarmThreshold = {threshHigh, threshLow};

  // ---------------------------------------------------------------
  // Pressure compensation
  // ---------------------------------------------------------------

  // Visible bytes; the low-byte commit writes the clamped pair back
  always_ff @(posedge core_clk) begin
    if (rst) begin
      presHigh <= RST_PRES_HIGH;
      presLow <= RST_PRES_LOW;
    end else if (wrPresLow) begin
      presHigh <= presClamped[15:8];
      presLow <= presClamped[7:0];
    end else if (wrPresHigh) begin
      presHigh <= acc.wdata;
    end
  end

  // Shadow loads only on the low-byte write, so a half-written pair never leaks
  always_ff @(posedge core_clk) begin
    if (rst) begin
      presShadow <= PRES_DEFAULT;
    end else if (wrPresLow) begin
      presShadow <= presClamped;
    end
  end

  // Reset value in the shadow means no compensation
  always_ff @(posedge core_clk) begin
    if (rst) begin
      compEnable <= 1'b0;
    end else if (wrPresLow) begin
      compEnable <= (presClamped != PRES_DEFAULT);
    end
  end

  // Downstream sees only the shadow copy
  assign pressureComp = presShadow;

  // ---------------------------------------------------------------
  // Calibration reference
  // ---------------------------------------------------------------

  // Either byte write stores the clamped pair in both bytes
  always_ff @(posedge core_clk) begin
    if (rst) begin
      refHigh <= RST_REF_HIGH;
      refLow <= RST_REF_LOW;
    end else if (wrRefHigh || wrRefLow) begin
      refHigh <= refClamped[15:8];
      refLow <= refClamped[7:0];
    end
  end

  assign calibReference = {refHigh, refLow};

  // ---------------------------------------------------------------
  // Status, mask and interrupt
  // ---------------------------------------------------------------

  logic errEvent;

  // A bad value on either clamped pair counts as a communication error
  assign errEvent = (wrPresLow && presOut) || ((wrRefHigh || wrRefLow) && refOut);

  // Write one to clear; a new error in the same cycle wins
  always_comb begin
    next_commErr = commError;
    if (wrStatus && acc.wdata[BIT_COMM_ERR]) begin
      next_commErr = 1'b0;
    end
    if (errEvent) begin
      next_commErr = 1'b1;
    end
    next_irqMask = wrMask ? acc.wdata[BIT_COMM_ERR] : irqMask;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      commError <= 1'b0;
    end else begin
      commError <= next_commErr;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      irqMask <= RST_MASK;
    end else begin
      irqMask <= next_irqMask;
    end
  end

  // Built from next values so the line tracks the flag with no extra lag
  always_ff @(posedge core_clk) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= next_commErr && next_irqMask;
    end
  end

  // ---------------------------------------------------------------
  // Read-back
  // ---------------------------------------------------------------

  // Unmapped indices read as zero
  always_comb begin
    case (acc.index)
      IDX_ALARM_CFG: acc.rdata = {7'h0, alarmUpward};
      IDX_THRESH_HIGH: acc.rdata = threshHigh;
      IDX_THRESH_LOW: acc.rdata = threshLow;
      IDX_PRES_HIGH: acc.rdata = presHigh;
      IDX_PRES_LOW: acc.rdata = presLow;
      IDX_REF_HIGH: acc.rdata = refHigh;
      IDX_REF_LOW: acc.rdata = refLow;
      IDX_STATUS: acc.rdata = {7'h0, commError};
      IDX_IRQ_MASK: acc.rdata = {7'h0, irqMask};
      IDX_SHADOW_HIGH: acc.rdata = presShadow[15:8];
      IDX_SHADOW_LOW: acc.rdata = presShadow[7:0];
      default: acc.rdata = 8'h00;
    endcase
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------

  default clocking cb @(posedge core_clk);
  endclocking

  default disable iff (rst);

  sequence s_pres_high_wr;
    wrPresHigh;
  endsequence

  sequence s_pres_low_wr;
    wrPresLow;
  endsequence

  property p_thresh_high;
    wrThreshHigh |=> alarmThreshold[15:8] == $past(acc.wdata);
  endproperty
  a_thresh_high: assert property (p_thresh_high)
    else $error("threshold high byte not stored");

  property p_thresh_low;
    wrThreshLow && !wrThreshHigh |=> alarmThreshold[7:0] == $past(acc.wdata);
  endproperty
  a_thresh_low: assert property (p_thresh_low)
    else $error("threshold low byte not stored");

  property p_shadow_commit;
    s_pres_low_wr ##0 !presOut |=> pressureComp == {$past(presHigh), $past(acc.wdata)};
  endproperty
  a_shadow_commit: assert property (p_shadow_commit)
    else $error("shadow did not take the written pair");

  property p_shadow_hold;
    s_pres_high_wr |=> $stable(pressureComp);
  endproperty
  a_shadow_hold: assert property (p_shadow_hold)
    else $error("high byte write moved the shadow");

  property p_shadow_only_on_low;
    !$stable(pressureComp) |-> $past(wrPresLow);
  endproperty
  a_shadow_only_on_low: assert property (p_shadow_only_on_low)
    else $error("shadow changed without a low byte write");

  property p_pres_clamp;
    s_pres_low_wr |=> pressureComp >= PRES_MIN && pressureComp <= PRES_MAX
      && {presHigh, presLow} == pressureComp;
  endproperty
  a_pres_clamp: assert property (p_pres_clamp)
    else $error("pressure not clamped or not written back");

  property p_ref_clamp;
    wrRefHigh || wrRefLow |=> $signed(calibReference) >= $signed(REF_MIN)
      && $signed(calibReference) <= $signed(REF_MAX);
  endproperty
  a_ref_clamp: assert property (p_ref_clamp)
    else $error("reference outside clamp range after write");

  property p_err_set;
    s_pres_low_wr ##0 presOut |=> commError ##1 commError || $past(wrStatus);
  endproperty
  a_err_set: assert property (p_err_set)
    else $error("out-of-range pressure did not flag an error");

  property p_comp_enable;
    s_pres_low_wr |=> compEnable == (pressureComp != PRES_DEFAULT);
  endproperty
  a_comp_enable: assert property (p_comp_enable)
    else $error("compensation enable disagrees with shadow");

  property p_irq_level;
    ##1 irq == (commError && irqMask);
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("interrupt line not equal to masked status");

  property p_dir_bit;
    wrCfg |=> alarmUpward == $past(acc.wdata[BIT_ALARM_DIR]);
  endproperty
  a_dir_bit: assert property (p_dir_bit)
    else $error("alarm direction bit not stored");

endmodule // compensation_threshold_regs
`default_nettype wire

// file: test/ahb_host_model.sv
// Behavioural AHB-Lite host issuing single transfers of the size each call gives to the register bank
`timescale 1ns/1ps
`default_nettype none
module ahb_host_model (
  input wire logic core_clk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  // Idle bus from time zero
  initial begin
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
  end
  // One transfer, entered just after a rising edge; waits for hready with no fixed count
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] wd,
      input logic [2:0] sz, output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= wr;
    hsize <= sz;
    do @(posedge core_clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    haddr <= ~a; // Released address never keeps its last value
    hwdata <= wr ? wd : ~hwdata;
    do @(posedge core_clk); while (hready !== 1'b1);
    rd = hrdata;
    hwdata <= ~wd; // Released data lines show a changing pattern
  endtask
endmodule // ahb_host_model
`default_nettype wire

// file: test/compensation_threshold_regs_tb_top.sv
// Self-checking bench for the compensation and threshold register bank
`timescale 1ns/1ps
`default_nettype none
module compensation_threshold_regs_tb_top;
  import comp_regs_pkg::*;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  wire logic hsel, hwrite, hreadyout, hresp, alarmUpward, compEnable, commError, irq;
  wire logic [31:0] haddr, hwdata, hrdata;
  wire logic [1:0] htrans;
  wire logic [2:0] hsize;
  wire logic signed [15:0] alarmThreshold, calibReference;
  wire logic [15:0] pressureComp;
  int regs[int];
  int errTotal = 0;
  int nCompared = 0;
  int seed = 32'h0161;
  int idxTab[11] = '{IDX_ALARM_CFG, IDX_THRESH_HIGH, IDX_THRESH_LOW, IDX_PRES_HIGH,
      IDX_PRES_LOW, IDX_REF_HIGH, IDX_REF_LOW, IDX_STATUS, IDX_IRQ_MASK, IDX_SHADOW_HIGH,
      IDX_SHADOW_LOW};
  int rstTab[11] = '{8'h01, 8'h00, 8'h00, 8'h03, 8'hf7, 8'h01, 8'h90, 8'h00, 8'h00, 8'h03, 8'hf7};
  int thTab[4] = '{16'h8000, 16'h7fff, 16'h1234, 16'hfe0c};
  int presTab[8] = '{749, 1150, 1151, 1015, 16'h0000, 750, 16'hffff, 900};
  int refTab[7] = '{16'h05dd, 16'h05dc, 16'h015d, 16'h015e, 16'hff00, 16'h7fff, 16'h0400};

  // 40 MHz clock
  always #12.5 core_clk = ~core_clk;

  compensation_threshold_regs i_dut (.core_clk(core_clk), .rst(rst), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
      .alarmThreshold(alarmThreshold), .alarmUpward(alarmUpward), .pressureComp(pressureComp),
      .compEnable(compEnable), .calibReference(calibReference), .commError(commError),
      .irq(irq));
  ahb_host_model i_host (.core_clk(core_clk), .hready(hreadyout), .hrdata(hrdata),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata));

  // ---------------------------------------------------------------
  // Reference model and checks
  // ---------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    nCompared++;
    if (got !== exp) begin
      errTotal++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // Any excursion is sticky in the model status until cleared by software
  function automatic int clampVal(input int v, input int lo, input int hi);
    if (v < lo || v > hi) regs[IDX_STATUS] = 1;
    clampVal = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction
  task automatic put2(input int h, input int l, input int v);
    regs[h] = (v >> 8) & 255;
    regs[l] = v & 255;
  endtask
  task automatic mdlWrite(input int i, input int d);
    int v;
    d = d & 255;
    if (i == IDX_PRES_LOW) begin
      v = clampVal(regs[IDX_PRES_HIGH] * 256 + d, 750, 1150);
      put2(IDX_PRES_HIGH, IDX_PRES_LOW, v);
      put2(IDX_SHADOW_HIGH, IDX_SHADOW_LOW, v);
    end else if (i == IDX_REF_HIGH || i == IDX_REF_LOW) begin
      v = (i == IDX_REF_HIGH) ? d * 256 + regs[IDX_REF_LOW] : regs[IDX_REF_HIGH] * 256 + d;
      if (v > 32767) v -= 65536;
      put2(IDX_REF_HIGH, IDX_REF_LOW, clampVal(v, 350, 1500));
    end else if (i == IDX_STATUS) begin
      if (d & 1) regs[IDX_STATUS] = 0;
    end else if (i == IDX_ALARM_CFG || i == IDX_IRQ_MASK) begin
      regs[i] = d & 1;
    end else if (regs.exists(i) && i != IDX_SHADOW_HIGH && i != IDX_SHADOW_LOW) begin
      regs[i] = d;
    end
  endtask
  task automatic chkOuts();
    chk("alarmThreshold", regs[IDX_THRESH_HIGH] * 256 + regs[IDX_THRESH_LOW],
        {16'h0000, alarmThreshold});
    chk("alarmUpward", regs[IDX_ALARM_CFG], {31'h0, alarmUpward});
    chk("pressureComp", regs[IDX_SHADOW_HIGH] * 256 + regs[IDX_SHADOW_LOW],
        {16'h0000, pressureComp});
    chk("compEnable", (regs[IDX_SHADOW_HIGH] * 256 + regs[IDX_SHADOW_LOW]) != 1015,
        {31'h0, compEnable});
    chk("calibReference", regs[IDX_REF_HIGH] * 256 + regs[IDX_REF_LOW],
        {16'h0000, calibReference});
    chk("commError", regs[IDX_STATUS], {31'h0, commError});
    chk("irq", regs[IDX_STATUS] & regs[IDX_IRQ_MASK], {31'h0, irq});
    chk("hresp", 0, {31'h0, hresp});
  endtask
  // Refused transfers write nothing and read zero
  task automatic acc(input logic wr, input logic [31:0] a, input int d, input logic [2:0] sz);
    logic [31:0] rd;
    logic ok;
    int i;
    ok = (sz == HSIZE_WORD) && (a[1:0] == 2'b00) && (a[31:10] == 22'h0);
    i = a[9:2];
    i_host.xfer(wr, a, d, sz, rd);
    if (wr && ok) mdlWrite(i, d);
    if (!wr) chk("hrdata", (ok && regs.exists(i)) ? regs[i] : 0, rd);
    chkOuts();
  endtask
  task automatic wrI(input int i, input int d);
    acc(1'b1, 32'(i * 4), d, HSIZE_WORD);
  endtask
  task automatic rdI(input int i);
    acc(1'b0, 32'(i * 4), 0, HSIZE_WORD);
  endtask
  task automatic doReset();
    rst <= 1'b1;
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    foreach (idxTab[k]) regs[idxTab[k]] = rstTab[k];
    foreach (idxTab[k]) rdI(idxTab[k]);
  endtask
  task automatic report_and_stop();
    if (errTotal == 0 && nCompared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  initial begin
    doReset();
    rdI(8'h10);
    acc(1'b1, 32'h0000_0028, $random(seed), 3'h0);
    acc(1'b1, 32'h0000_0029, $random(seed), HSIZE_WORD);
    acc(1'b1, 32'h0000_0428, $random(seed), HSIZE_WORD);
    acc(1'b0, 32'h0000_0428, 0, HSIZE_WORD);
    wrI(8'h10, $random(seed));
    wrI(IDX_SHADOW_LOW, 8'h00);
    rdI(IDX_THRESH_LOW);
    for (int k = 0; k < 4; k++) begin
      wrI(IDX_THRESH_HIGH, thTab[k] >> 8);
      wrI(IDX_THRESH_LOW, thTab[k]);
      wrI(IDX_ALARM_CFG, k);
      rdI(IDX_ALARM_CFG);
    end
    presTab[7] = 750 + ({$random(seed)} % 401);
    foreach (presTab[k]) begin
      wrI(IDX_PRES_HIGH, presTab[k] >> 8);
      rdI(IDX_SHADOW_HIGH);
      wrI(IDX_PRES_LOW, presTab[k]);
      rdI(IDX_PRES_HIGH);
      rdI(IDX_PRES_LOW);
      rdI(IDX_SHADOW_LOW);
    end
    // Sticky error with the mask opened, then a write-one clear
    wrI(IDX_IRQ_MASK, 1);
    wrI(IDX_STATUS, 0);
    rdI(IDX_STATUS);
    wrI(IDX_STATUS, 1);
    rdI(IDX_IRQ_MASK);
    foreach (refTab[k]) begin
      wrI(IDX_REF_HIGH, refTab[k] >> 8);
      wrI(IDX_REF_LOW, refTab[k]);
      rdI(IDX_REF_HIGH);
      rdI(IDX_REF_LOW);
    end
    doReset();
    report_and_stop();
  end
  // Watchdog, far beyond the 127 transfers of the run
  initial begin
    repeat (20000) @(posedge core_clk);
    errTotal++;
    report_and_stop();
  end
endmodule // compensation_threshold_regs_tb_top
`default_nettype wire
